// *** src/dtr_fast_read_engine.sv ***
// Functional notes
// - Single lane: one address bit per edge.
// - Single lane: one data bit per edge.
// - Address increments per byte, wraps to zero.
// - Single order: command, address, six dummies, data.
// - Select high ends the command at once.
// - Reads with an instruction rejected while a write cycle runs.
// - Dual lane: two address bits per edge.
// - Dual lane: two data bits per edge.
// - Dual order: command, address, six dummies, data.
// - Quad lane: four bits per edge.
// - Quad order: command, address, mode byte, seven dummies, data.
// - Enhanced: mode byte, seven dummies, no command.
// - Clear command drops continuation mode.
`timescale 1ns/10ps
`include "dtr_read_params.svh"
`default_nettype none
module dtr_fast_read_engine
  import dtr_read_pkg::*;
(
  input  wire logic        clock,          // System clock.
  input  wire logic        nrst,           // Asynchronous reset, active low.
  input  wire logic        sclk,           // Serial clock from the host.
  input  wire logic        cs_n,           // Chip select, active low.
  input  wire logic [3:0]  io_in,          // Lanes io_lane_3..io_lane_0 as seen at the pins.
  output logic      [3:0]  io_out,         // Driven lane values.
  output logic      [3:0]  io_oe,          // Lane output enables, high while driving.
  input  wire logic        quad_io_enable, // Status quad enable bit.
  input  wire logic        write_busy,     // Program, erase or status write in progress.
  output logic             mem_req,        // Pulses for one clock when a new byte address is wanted.
  output logic [23:0]      mem_addr,       // Byte address for the memory array.
  input  wire logic [7:0]  mem_data,       // Byte read back, valid before it is needed.
  output logic             cont_mode       // Enhanced continuation armed.
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side. The link logic runs on both edges of sclk: the rising edge
  // half and the falling edge half each own their own registers, and the
  // select line resets both so nothing depends on edges outside a frame.

  phase_t             phase_reg;       // Current phase, owned by the rising half.
  width_t             width_reg;       // Lane width for address and data.
  logic [7:0]         cmd_reg;         // Instruction shift register.
  logic [2:0]         cmd_cnt_reg;     // Instruction bit count.
  logic [23:0]        addr_reg;        // Address shift register and counter.
  logic [5:0]         bit_cnt_reg;     // Bits taken or sent in current phase.
  logic [3:0]         dummy_cnt_reg;   // Dummy clocks remaining.
  logic [7:0]         mode_reg;        // Mode byte shift register.
  logic               enh_reg;         // Enhanced mode chosen for this frame.
  logic               cont_reg;        // Continuation armed for the next frame.
  logic [3:0]         fall_in_reg;     // Lane value caught on the falling edge.
  logic               req_tgl_reg;     // Byte address request toggle.
  logic [7:0]         shift_out_reg;   // Data byte being sent.
  logic [3:0]         out_r_reg;       // Lane drive from the rising half.
  logic [3:0]         out_f_reg;       // Lane drive from the falling half.
  logic               drive_reg;       // Output phase active.

  // Number of lanes in use for a width.
  function automatic logic [2:0] lanes(input width_t w);
    unique case (w)
      W_ONE:   lanes = 3'd1;
      W_TWO:   lanes = 3'd2;
      W_FOUR:  lanes = 3'd4;
      default: lanes = 3'd1;
    endcase
  endfunction : lanes

  // Append one edge worth of lane bits to an address shift register.
  function automatic logic [23:0] shift_addr(input logic [23:0] a, input width_t w, input logic [3:0] v);
    unique case (w)
      W_ONE:   shift_addr = {a[22:0], v[0]};
      W_TWO:   shift_addr = {a[21:0], v[1:0]};
      W_FOUR:  shift_addr = {a[19:0], v};
      default: shift_addr = a;
    endcase
  endfunction : shift_addr

  // Place the top bits of a byte on the lanes for one edge.
  function automatic logic [3:0] lane_bits(input logic [7:0] d, input width_t w);
    unique case (w)
      W_ONE:   lane_bits = {2'b00, d[7], 1'b0};  // Single lane sends on io_lane_1.
      W_TWO:   lane_bits = {2'b00, d[7:6]};
      W_FOUR:  lane_bits = d[7:4];
      default: lane_bits = 4'h0;
    endcase
  endfunction : lane_bits

  // Next byte address, wrapping to zero past the top of the array.
  function automatic logic [23:0] next_addr(input logic [23:0] a);
    next_addr = (a == `ADDR_TOP) ? 24'h00_0000 : a + 24'd1;
  endfunction : next_addr

  ////////////////////////////////////////////////////////////////////////////
  // Status levels from the system side are re-timed on sclk before the
  // sequencer reads them. They only need to be settled by the sixth
  // instruction bit, two before the last, which leaves several clocks of margin in every frame.

  logic [1:0]         busy_sync_reg;   // Write-in-progress level, two flip-flops.
  logic [1:0]         qe_sync_reg;     // Quad enable level, two flip-flops.

  // Crossing flip-flops for the status levels; select does not clear them.
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_sync_reg <= 2'b00;
      qe_sync_reg   <= 2'b00;
    end
    else
    begin
      busy_sync_reg <= {busy_sync_reg[0], write_busy};
      qe_sync_reg   <= {qe_sync_reg[0], quad_io_enable};
    end
  end

  // Falling half: catches the lane value for the next rising edge.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      fall_in_reg  <= 4'h0;
    end
    else
    begin
      fall_in_reg  <= io_in;
    end
  end

  // Falling half output: sends the group that follows the one put out on
  // the rising edge, so each edge of the clock carries fresh bits.
  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      out_f_reg <= 4'h0;
    else
      out_f_reg <= lane_bits(shift_out_reg << lanes(width_reg), width_reg);
  end

  // Rising half: the whole command sequencer. In the address and mode phases
  // each rising edge first folds in the bits caught on the previous falling
  // edge, then the bits present now, so every edge there carries a lane group.
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      phase_reg     <= PH_CMD;
      width_reg     <= W_ONE;
      cmd_reg       <= 8'h00;
      cmd_cnt_reg   <= 3'd0;
      addr_reg      <= 24'h00_0000;
      bit_cnt_reg   <= 6'd0;
      dummy_cnt_reg <= 4'd0;
      mode_reg      <= 8'h00;
      enh_reg       <= 1'b0;
      drive_reg     <= 1'b0;
      shift_out_reg <= 8'h00;
      out_r_reg     <= 4'h0;
      req_tgl_reg   <= 1'b0;
    end
    else
    begin
      unique case (phase_reg)
        PH_CMD:
        begin
          // Armed continuation skips the instruction and goes to address.
          if (cont_reg && cmd_cnt_reg == 3'd0 && bit_cnt_reg == 6'd0)
          begin
            width_reg   <= W_FOUR;
            enh_reg     <= 1'b1;
            // The frame's first falling edge already brought the top nibble.
            addr_reg    <= {16'h0000, fall_in_reg, io_in};
            bit_cnt_reg <= 6'd8;
            phase_reg   <= PH_ADDR;
          end
          else
          begin
            cmd_reg     <= {cmd_reg[6:0], io_in[0]};
            cmd_cnt_reg <= cmd_cnt_reg + 3'd1;
            if (cmd_cnt_reg == 3'd7)
            begin
              bit_cnt_reg <= 6'd0;
              phase_reg   <= PH_ADDR;
              if (busy_sync_reg[1])
                phase_reg <= PH_IDLE;
              else
              begin
                unique case ({cmd_reg[6:0], io_in[0]})
                  `CMD_DTR_SINGLE_READ: width_reg <= W_ONE;
                  `CMD_DTR_DUAL_READ:   width_reg <= W_TWO;
                  `CMD_DTR_QUAD_READ:
                  begin
                    width_reg <= W_FOUR;
                    enh_reg   <= 1'b1;
                    if (!qe_sync_reg[1])
                      phase_reg <= PH_IDLE;
                  end
                  default:              phase_reg <= PH_IDLE;
                endcase
              end
            end
          end
        end
        PH_ADDR:
        begin
          // Two lane groups per clock: the falling one, then the rising one.
          addr_reg    <= shift_addr(shift_addr(addr_reg, width_reg, fall_in_reg), width_reg, io_in);
          bit_cnt_reg <= bit_cnt_reg + {2'b00, lanes(width_reg), 1'b0};
          if (bit_cnt_reg + {2'b00, lanes(width_reg), 1'b0} >= 6'd24)
          begin
            bit_cnt_reg <= 6'd0;
            if (width_reg == W_FOUR && enh_reg)
              phase_reg <= PH_MODE;
            else
            begin
              dummy_cnt_reg <= (width_reg == W_FOUR) ? 4'(`DUMMY_QUAD)
                             : (width_reg == W_TWO)  ? 4'(`DUMMY_DUAL)
                             : 4'(`DUMMY_SINGLE);
              phase_reg     <= PH_DUMMY;
            end
          end
        end
        PH_MODE:
        begin
          // One clock carries the whole mode byte on four lanes.
          mode_reg      <= {fall_in_reg, io_in};
          dummy_cnt_reg <= 4'(`DUMMY_QUAD_ENH);
          phase_reg     <= PH_DUMMY;
        end
        PH_DUMMY:
        begin
          dummy_cnt_reg <= dummy_cnt_reg - 4'd1;
          if (dummy_cnt_reg == 4'd2)
            req_tgl_reg <= ~req_tgl_reg;          // Fetch the first byte early.
          if (dummy_cnt_reg == 4'd1)
          begin
            phase_reg     <= PH_DATA;
            drive_reg     <= 1'b1;
            shift_out_reg <= mem_data;
            out_r_reg     <= lane_bits(mem_data, width_reg);
            // Ask for the following byte now, so it has a whole byte time to arrive.
            addr_reg      <= next_addr(addr_reg);
            req_tgl_reg   <= ~req_tgl_reg;
          end
        end
        PH_DATA:
        begin
          // Consume the two lane groups sent during the clock just ended.
          bit_cnt_reg <= bit_cnt_reg + {2'b00, lanes(width_reg), 1'b0};
          if (bit_cnt_reg + {2'b00, lanes(width_reg), 1'b0} >= 6'd8)
          begin
            bit_cnt_reg   <= 6'd0;
            addr_reg      <= next_addr(addr_reg);
            req_tgl_reg   <= ~req_tgl_reg;
            shift_out_reg <= mem_data;
            out_r_reg     <= lane_bits(mem_data, width_reg);
          end
          else
          begin
            shift_out_reg <= shift_out_reg << (2 * lanes(width_reg));
            out_r_reg     <= lane_bits(shift_out_reg << (2 * lanes(width_reg)), width_reg);
          end
        end
        PH_IDLE:
          phase_reg <= PH_IDLE;                   // Ignore the rest of the frame.
        default:
          phase_reg <= PH_IDLE;
      endcase
    end
  end

  // Continuation state survives across frames, so it has its own reset and
  // changes only at the clock that ends the mode byte or the clear command.
  always_ff @(posedge sclk or negedge nrst)
  begin
    if (!nrst)
      cont_reg <= 1'b0;
    else if (!cs_n && phase_reg == PH_MODE)
      cont_reg <= (fall_in_reg == `CONT_PATTERN);
    else if (!cs_n && phase_reg == PH_CMD && cmd_cnt_reg == 3'd7
             && {cmd_reg[6:0], io_in[0]} == `CMD_CONT_CLEAR)
      cont_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. The lane pins belong to the link, so they are not re-timed
  // on the system clock; select high removes the drive at once.

  always_comb
  begin
    io_out = sclk ? out_r_reg : out_f_reg;
    io_oe  = 4'h0;
    if (drive_reg && !cs_n)
    begin
      unique case (width_reg)
        W_ONE:   io_oe = 4'b0010;
        W_TWO:   io_oe = 4'b0011;
        W_FOUR:  io_oe = 4'b1111;
        default: io_oe = 4'b0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System side. The request toggle and the address cross into the clock
  // domain; the address is stable well before the toggle is seen.

  logic [2:0]  req_sync_reg;   // Toggle synchroniser with edge history.
  logic [1:0]  cont_sync_reg;  // Level synchroniser for continuation state.

  // Crossing flip-flops for the request toggle.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      req_sync_reg <= 3'b000;
    else
      req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
  end

  // Registered memory request pulse and address.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      mem_req  <= 1'b0;
      mem_addr <= 24'h00_0000;
    end
    else
    begin
      mem_req <= req_sync_reg[2] ^ req_sync_reg[1];
      if (req_sync_reg[2] ^ req_sync_reg[1])
        mem_addr <= addr_reg;
    end
  end

  // Continuation state reported on the system clock.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      cont_sync_reg <= 2'b00;
      cont_mode     <= 1'b0;
    end
    else
    begin
      cont_sync_reg <= {cont_sync_reg[0], cont_reg};
      cont_mode     <= cont_sync_reg[1];
    end
  end

endmodule : dtr_fast_read_engine
`default_nettype wire

// *** src/dtr_read_params.svh ***
`ifndef DTR_READ_PARAMS_SVH
`define DTR_READ_PARAMS_SVH
// Instruction codes; the values are arbitrary and can be changed freely.
`define CMD_DTR_SINGLE_READ 8'h0D
`define CMD_DTR_DUAL_READ   8'hBD
`define CMD_DTR_QUAD_READ   8'hED
`define CMD_CONT_CLEAR      8'hFF
// Address width and the top address of the array.
`define ADDR_W              24
`define ADDR_TOP            24'hFF_FFFF
// Dummy clock counts per mode.
`define DUMMY_SINGLE        6
`define DUMMY_DUAL          6
`define DUMMY_QUAD          8
`define DUMMY_QUAD_ENH      7
// Upper nibble of the mode byte that keeps enhanced mode.
`define CONT_PATTERN        4'hA
// Serial clock ceiling for single-lane DTR reads, in MHz.
`define DTR_CLOCK_LIMIT_MHZ 66
`endif

// *** src/dtr_read_pkg.sv ***
`default_nettype none
package dtr_read_pkg;
  // Phase of a selection.
  typedef enum logic [2:0] {
    PH_CMD   = 3'b000,
    PH_ADDR  = 3'b001,
    PH_MODE  = 3'b010,
    PH_DUMMY = 3'b011,
    PH_DATA  = 3'b100,
    PH_IDLE  = 3'b101
  } phase_t;
  // Lane width of the command in progress.
  typedef enum logic [1:0] {
    W_ONE  = 2'b00,
    W_TWO  = 2'b01,
    W_FOUR = 2'b10
  } width_t;
endpackage : dtr_read_pkg
`default_nettype wire

// *** verif/dtr_read_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the engine's pins from the system clock domain.
module dtr_read_checker (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        cs_n,
  input wire logic [3:0]  io_oe,
  input wire logic        quad_io_enable,
  input wire logic        write_busy,
  input wire logic        mem_req,
  input wire logic [23:0] mem_addr,
  input wire logic        cont_mode
);
  logic busy_reg; // Busy level frozen when a frame opens.
  // Follows the busy flag only while deselected, so a late busy cannot blame a good frame.
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      busy_reg <= 1'b0;
    else if (cs_n)
      busy_reg <= write_busy;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_idle_quiet; cs_n |-> io_oe == 4'h0; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("lanes driven while deselected");
  property p_oe_code; io_oe inside {4'h0, 4'h2, 4'h3, 4'hF}; endproperty
  a_oe_code: assert property (p_oe_code) else $error("illegal lane enable set");
  property p_oe_fixed; !cs_n && $past(!cs_n) && $past(io_oe) != 4'h0 |-> io_oe == $past(io_oe); endproperty
  a_oe_fixed: assert property (p_oe_fixed) else $error("lane width changed in a frame");
  property p_busy_refuse; !cs_n && busy_reg |-> io_oe == 4'h0; endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("read served while busy");
  property p_quad_enable; io_oe == 4'hF |-> quad_io_enable; endproperty
  a_quad_enable: assert property (p_quad_enable) else $error("quad read without enable");
  property p_req_pulse; mem_req |=> !mem_req; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("fetch request too long");
  property p_addr_step;
    $past(io_oe) != 4'h0 && io_oe != 4'h0 && mem_addr != $past(mem_addr) |-> mem_addr == $past(mem_addr) + 24'h00_0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("address did not step by one");
  property p_late_data; $rose(io_oe != 4'h0) |-> $past(!cs_n, 150); endproperty
  a_late_data: assert property (p_late_data) else $error("data before dummies ended");
  c_single: cover property (io_oe == 4'h2);
  c_dual: cover property (io_oe == 4'h3);
  c_quad: cover property (io_oe == 4'hF);
  c_cont: cover property ($rose(cont_mode));
endmodule : dtr_read_checker
bind dtr_fast_read_engine dtr_read_checker dtr_read_checker_inst (.clock, .nrst, .cs_n, .io_oe, .quad_io_enable,
  .write_busy, .mem_req, .mem_addr, .cont_mode);
`default_nettype wire

// *** verif/spi_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host side of the link: drives select, serial clock and lanes, gathers bytes.
module spi_host_model (
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] io_drv,
  input  wire logic [3:0] io_bus,
  input  wire logic [3:0] io_oe
);
  logic [7:0] rx [0:15]; // Bytes gathered in the data phase.
  logic [3:0] rx_oe;     // Every lane enable seen in the frame.
  logic [3:0] smp;       // Lanes sampled just before an edge.
  initial
  begin
    sclk = 1'b0;
    io_drv = 4'h0;
    // Select rises just after time zero so the link logic sees a reset edge.
    #1 cs_n = 1'b1;
  end
  // One half period: lanes set up, device sampled, then the clock moves.
  task automatic step(input logic [3:0] v);
    io_drv = v;
    #40;
    smp = io_bus;
    rx_oe = rx_oe | io_oe;
    sclk = ~sclk;
    #40;
  endtask : step
  // Instruction if asked, na address groups, nd dummy clocks, ng data groups.
  task automatic frame(input logic [7:0] cmd, input bit has_cmd, input int w, input logic [31:0] am,
                       input int na, input int nd, input int ng);
    int i;
    logic [7:0] d;
    logic [3:0] g;
    rx_oe = 4'h0;
    d = 8'h00;
    sclk = !has_cmd;
    #43;
    cs_n = 1'b0;
    #40;
    if (has_cmd)
      for (i = 0; i < 15; i++) step({3'b000, cmd[7 - i / 2]});
    for (i = 0; i < na; i++) step(am[31 - i * w -: 4] >> (4 - w));
    // Lanes are left toggling in the dummies, as a released bus would.
    for (i = 0; i < 2 * nd; i++) step(~io_drv);
    for (i = 0; i < ng; i++)
    begin
      step(~io_drv);
      g = w == 1 ? {3'b000, smp[1]} : smp & (4'hF >> (4 - w));
      d = (d << w) | {4'h0, g};
      if ((i + 1) % (8 / w) == 0)
        rx[(i + 1) * w / 8 - 1] = d;
    end
    #40;
    cs_n = 1'b1;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dtr_read_params.svh"
module tb;
  logic        clock, nrst, sclk, cs_n, quad_io_enable, write_busy, mem_req, cont_mode, exp_cont;
  logic [3:0]  io_in, io_out, io_oe, io_drv;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  int          failures, checked, seed, w;
  // Array contents are a pure function of the address.
  function automatic logic [7:0] mem_fn(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : mem_fn
  assign mem_data = mem_fn(mem_addr);
  // Each lane shows whichever side enables it.
  assign io_in = (io_oe & io_out) | (~io_oe & io_drv);
  dtr_fast_read_engine dtr_fast_read_engine_inst (.clock, .nrst, .sclk, .cs_n, .io_in, .io_out, .io_oe,
    .quad_io_enable, .write_busy, .mem_req, .mem_addr, .mem_data, .cont_mode);
  spi_host_model spi_host_model_inst (.sclk, .cs_n, .io_drv, .io_bus(io_in), .io_oe);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  ////////////////////////////////////////
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bits(input string what, input logic [3:0] exp, input logic [3:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_bits
  function automatic logic [7:0] cmd_of(input int w);
    return w == 1 ? `CMD_DTR_SINGLE_READ : w == 2 ? `CMD_DTR_DUAL_READ : `CMD_DTR_QUAD_READ;
  endfunction : cmd_of
  // One read frame; ok low means the device must stay silent.
  task automatic rd(input logic [7:0] cmd, input bit has_cmd, input int w, input logic [23:0] a,
                    input logic [7:0] md, input int nb, input bit ok);
    int i;
    logic [3:0] oe;
    oe = !ok ? 4'h0 : w == 1 ? 4'h2 : w == 2 ? 4'h3 : 4'hF;
    @(negedge clock);
    spi_host_model_inst.frame(cmd, has_cmd, w, {a, md}, (w == 4 ? 32 : 24) / w,
                              w == 4 ? `DUMMY_QUAD_ENH : w == 2 ? `DUMMY_DUAL : `DUMMY_SINGLE, nb * 8 / w);
    chk_bits("lane enables", oe, spi_host_model_inst.rx_oe);
    for (i = 0; i < nb && ok; i++) chk_byte("read byte", mem_fn(24'(a + i)), spi_host_model_inst.rx[i]);
    #7 chk_bits("lanes after release", 4'h0, io_oe);
    if (ok && w == 4)
      exp_cont = md[7:4] == `CONT_PATTERN;
    repeat (10) @(negedge clock);
    chk_bits("continuation", {3'b000, exp_cont}, {3'b000, cont_mode});
  endtask : rd
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////
  // Main sequence; the watchdog below cuts a hang short.
  initial
  begin
    seed = 32'h16a5_dcef;
    nrst = 1'b1;
    quad_io_enable = 1'b1;
    write_busy = 1'b0;
    exp_cont = 1'b0;
    // Reset falls after time zero so every reset process sees the edge.
    #1 nrst = 1'b0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    // Each width: wrap at the top, then random starts and lengths.
    for (w = 1; w <= 4; w = w * 2)
    begin
      rd(cmd_of(w), 1, w, 24'hFF_FFFE, 8'h00, 3, 1);
      repeat (4) rd(cmd_of(w), 1, w, 24'($random(seed)), 8'($random(seed)) & 8'h7F, 1 + ($random(seed) & 3), 1);
    end
    rd(cmd_of(4), 1, 4, 24'h12_3456, 8'hA5, 2, 1);
    rd(8'h00, 0, 4, 24'hAB_CDEF, 8'hA0, 2, 1);
    rd(8'h00, 0, 4, 24'h00_0010, 8'h3C, 2, 1);
    rd(cmd_of(1), 1, 1, 24'h00_0020, 8'h00, 1, 1);
    rd(cmd_of(4), 1, 4, 24'h00_0030, 8'hAF, 1, 1);
    @(negedge clock);
    spi_host_model_inst.frame(`CMD_CONT_CLEAR, 1, 1, 32'h0, 0, 0, 0);
    exp_cont = 1'b0;
    rd(cmd_of(2), 1, 2, 24'h00_0040, 8'h00, 2, 1);
    write_busy = 1'b1;
    rd(cmd_of(2), 1, 2, 24'h00_0100, 8'h00, 1, 0);
    write_busy = 1'b0;
    quad_io_enable = 1'b0;
    rd(cmd_of(4), 1, 4, 24'h00_0100, 8'h00, 1, 0);
    quad_io_enable = 1'b1;
    rd(8'h3C, 1, 1, 24'h00_0100, 8'h00, 1, 0);
    @(negedge clock);
    spi_host_model_inst.frame(cmd_of(1), 1, 1, 32'h0002_0000, 24, 6, 11);
    chk_byte("aborted read byte", mem_fn(24'h00_0200), spi_host_model_inst.rx[0]);
    #7 chk_bits("lanes after abort", 4'h0, io_oe);
    rd(cmd_of(1), 1, 1, 24'h00_0300, 8'h00, 2, 1);
    summarize();
  end
  initial
  begin
    #800_000;
    failures++;
    summarize();
  end
endmodule : tb
`default_nettype wire
